/* File: design/psq_pkg.sv */
// Package for the power sequencer timing and power-mode register block.
// Assumes a 100 MHz APB clock; shared by the top and its slot timer.
package psq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAKE_CFG    = 8'h94;
  localparam logic [7:0] IDX_UP_DOWN     = 8'h95;
  localparam logic [7:0] IDX_SLEEP_ENTEX = 8'h96;
  localparam logic [7:0] IDX_BUCK_MODE   = 8'h97;
  localparam logic [7:0] IDX_LINREG_MODE = 8'h98;
  localparam logic [7:0] IDX_LINREG_SRC  = 8'hA0;
  localparam logic [7:0] IDX_STATUS      = 8'hA1;

  // Field positions
  localparam int HI_FIELD_LSB = 4;
  localparam int LO_FIELD_LSB = 0;
  localparam int PERIOD_W     = 3;
  localparam int MODE_W       = 2;
  localparam int NUM_BUCK     = 4;
  localparam int NUM_LINREG   = 4;
  localparam int NUM_SEQ      = 3;

  // Reset values
  localparam logic       WAKE_EN0_RST   = 1'b1;
  localparam logic [7:0] LINREG_SRC_RST = 8'hFF;

  // Encodings
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_FOLLOW_LP = 2'h1;
  localparam logic [1:0] MODE_FORCE_LP  = 2'h2;
  localparam logic [1:0] SRC_NONE       = 2'h3;

  // Slot period times in microseconds, then in cycles
  localparam int CLK_MHZ   = 100;
  localparam int SLOT0_US  = 31;
  localparam int SLOT1_US  = 63;
  localparam int SLOT2_US  = 127;
  localparam int SLOT3_US  = 253;
  localparam int SLOT4_US  = 508;
  localparam int SLOT5_US  = 984;
  localparam int SLOT6_US  = 1936;
  localparam int SLOT7_US  = 3904;
  localparam int SLOT_CNT_W = 20;
  localparam logic [7:0][SLOT_CNT_W-1:0] SLOT_CYC_DEF = {
    SLOT_CNT_W'(SLOT7_US * CLK_MHZ), SLOT_CNT_W'(SLOT6_US * CLK_MHZ),
    SLOT_CNT_W'(SLOT5_US * CLK_MHZ), SLOT_CNT_W'(SLOT4_US * CLK_MHZ),
    SLOT_CNT_W'(SLOT3_US * CLK_MHZ), SLOT_CNT_W'(SLOT2_US * CLK_MHZ),
    SLOT_CNT_W'(SLOT1_US * CLK_MHZ), SLOT_CNT_W'(SLOT0_US * CLK_MHZ)};

  typedef enum logic [2:0] {
    PHASE_IDLE        = 3'b000,
    PHASE_POWER_UP    = 3'b001,
    PHASE_POWER_DOWN  = 3'b010,
    PHASE_SLEEP_ENTRY = 3'b011,
    PHASE_SLEEP_EXIT  = 3'b100
  } psq_phase_t;

  // Stored defaults presented to the block at reset
  typedef struct packed {
    logic       wake_on_enable0_event;
    logic [2:0] master_powerup_period;
    logic [2:0] master_powerdown_period;
    logic [2:0] master_sleep_entry_period;
    logic [2:0] master_sleep_exit_period;
    logic [7:0] buck_power_mode;
    logic [7:0] linreg_power_mode;
  } psq_defaults_t;

  typedef struct packed {
    logic [3:0] lowpower;
    logic [3:0] enable;
  } psq_reg_ctl_t;

endpackage : psq_pkg

/* File: design/psq_slot_timer.sv */
// Slot timer: emits one tick per selected slot period while running.
// Assumes the code is steady during a phase; a change applies at once to the slot in progress.
`timescale 1ns/1ns
`default_nettype none
module psq_slot_timer #(
  parameter int                                    CNT_W    = psq_pkg::SLOT_CNT_W,
  parameter logic [7:0][psq_pkg::SLOT_CNT_W-1:0]   SLOT_CYC = psq_pkg::SLOT_CYC_DEF
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              run,
  input  wire logic [psq_pkg::PERIOD_W-1:0]      code,
  output var  logic                              tick
);
  import psq_pkg::*;

  generate
    if (CNT_W != SLOT_CNT_W) begin : g_bad_width
      $error("psq_slot_timer: CNT_W must equal the slot count width");
    end
    for (genvar i = 0; i < 8; i++) begin : g_chk
      if (SLOT_CYC[i] == '0) begin : g_zero
        $error("psq_slot_timer: slot period of zero cycles");
      end
    end
  endgenerate

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             tick_nxt;
  wire  logic [CNT_W-1:0] last_cnt = SLOT_CYC[code] - CNT_W'(1);
  wire  logic             at_end   = (count_r >= last_cnt);

  // Counter clears while idle so a phase entered from idle starts a fresh slot
  assign count_nxt = (!run || at_end) ? '0 : count_r + CNT_W'(1);
  assign tick_nxt  = run && at_end;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      tick    <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick    <= tick_nxt;
    end
  end

endmodule : psq_slot_timer
`default_nettype wire

/* File: design/psq_regs.sv */
// Top of the sequencer timing and power-mode register block, APB slave.
// Assumes word-aligned APB accesses and inputs synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module psq_regs #(
  parameter logic [7:0][psq_pkg::SLOT_CNT_W-1:0] SLOT_CYC = psq_pkg::SLOT_CYC_DEF
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire psq_pkg::psq_defaults_t  stored_defaults,
  input  wire logic                    enable0_input,
  input  wire logic                    global_lowpower,
  input  wire logic [2:0]              flexible_sequencer_active,
  input  wire psq_pkg::psq_phase_t     seq_phase,
  output var  logic                    wakeup,
  output var  logic                    slot_tick,
  output var  psq_pkg::psq_reg_ctl_t   buck_ctl,
  output var  psq_pkg::psq_reg_ctl_t   linreg_ctl
);
  import psq_pkg::*;

  generate
    if (NUM_SEQ != 3) begin : g_bad_seq
      $error("psq_regs: source field codes exactly three sequencers");
    end
  endgenerate

  // Register storage; reserved bits are not stored
  logic       wake_on_enable0_event_r;
  logic [2:0] master_powerup_period_r;
  logic [2:0] master_powerdown_period_r;
  logic [2:0] master_sleep_entry_period_r;
  logic [2:0] master_sleep_exit_period_r;
  logic [7:0] buck_power_mode_r;
  logic [7:0] linreg_power_mode_r;
  logic [7:0] linreg_sequencer_source_r;
  logic       init_pend_r;

  // APB decode
  wire logic [7:0] idx        = paddr[9:2];
  wire logic       addr_hi_ok = (paddr[11:10] == 2'h0);
  wire logic       access     = psel && penable;
  wire logic       done       = access && pready;
  wire logic       wr_done    = done && pwrite;
  wire logic       sel_wake   = addr_hi_ok && (idx == IDX_WAKE_CFG);
  wire logic       sel_updn   = addr_hi_ok && (idx == IDX_UP_DOWN);
  wire logic       sel_sleep  = addr_hi_ok && (idx == IDX_SLEEP_ENTEX);
  wire logic       sel_buck   = addr_hi_ok && (idx == IDX_BUCK_MODE);
  wire logic       sel_lmode  = addr_hi_ok && (idx == IDX_LINREG_MODE);
  wire logic       sel_lsrc   = addr_hi_ok && (idx == IDX_LINREG_SRC);
  wire logic       sel_stat   = addr_hi_ok && (idx == IDX_STATUS);
  wire logic       mapped     = sel_wake || sel_updn || sel_sleep || sel_buck
                             || sel_lmode || sel_lsrc || sel_stat;

  // Read mux; bits 7 and 3 of period registers read zero
  wire logic [7:0] rd_updn  = {1'b0, master_powerup_period_r, 1'b0,
                               master_powerdown_period_r};
  wire logic [7:0] rd_sleep = {1'b0, master_sleep_entry_period_r, 1'b0,
                               master_sleep_exit_period_r};
  wire logic [15:0] rd_stat = {linreg_ctl, buck_ctl};
  wire logic [31:0] rd_word =
      sel_wake  ? {31'h0, wake_on_enable0_event_r} :
      sel_updn  ? {24'h0, rd_updn} :
      sel_sleep ? {24'h0, rd_sleep} :
      sel_buck  ? {24'h0, buck_power_mode_r} :
      sel_lmode ? {24'h0, linreg_power_mode_r} :
      sel_lsrc  ? {24'h0, linreg_sequencer_source_r} :
      sel_stat  ? {16'h0, rd_stat} : 32'h0;

  // One wait state: ready is a flop, raised in the second access cycle
  wire logic        pready_nxt  = access && !pready;
  wire logic [31:0] prdata_nxt  = (pready_nxt && !pwrite) ? rd_word : 32'h0;
  wire logic        pslverr_nxt = pready_nxt && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_nxt;
      prdata  <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Writes land at the edge that completes the transfer
  wire logic wr_wake  = wr_done && sel_wake;
  wire logic wr_updn  = wr_done && sel_updn;
  wire logic wr_sleep = wr_done && sel_sleep;
  wire logic wr_buck  = wr_done && sel_buck;
  wire logic wr_lmode = wr_done && sel_lmode;
  wire logic wr_lsrc  = wr_done && sel_lsrc;

  // Constants under reset; stored defaults are caught at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pend_r <= 1'b1;
    end else begin
      init_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_on_enable0_event_r <= WAKE_EN0_RST;
    end else if (init_pend_r) begin
      wake_on_enable0_event_r <= stored_defaults.wake_on_enable0_event;
    end else if (wr_wake) begin
      wake_on_enable0_event_r <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_powerup_period_r   <= 3'h0;
      master_powerdown_period_r <= 3'h0;
    end else if (init_pend_r) begin
      master_powerup_period_r   <= stored_defaults.master_powerup_period;
      master_powerdown_period_r <= stored_defaults.master_powerdown_period;
    end else if (wr_updn) begin
      master_powerup_period_r   <= pwdata[HI_FIELD_LSB +: PERIOD_W];
      master_powerdown_period_r <= pwdata[LO_FIELD_LSB +: PERIOD_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_sleep_entry_period_r <= 3'h0;
      master_sleep_exit_period_r  <= 3'h0;
    end else if (init_pend_r) begin
      master_sleep_entry_period_r <= stored_defaults.master_sleep_entry_period;
      master_sleep_exit_period_r  <= stored_defaults.master_sleep_exit_period;
    end else if (wr_sleep) begin
      master_sleep_entry_period_r <= pwdata[HI_FIELD_LSB +: PERIOD_W];
      master_sleep_exit_period_r  <= pwdata[LO_FIELD_LSB +: PERIOD_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_power_mode_r   <= 8'h0;
      linreg_power_mode_r <= 8'h0;
    end else if (init_pend_r) begin
      buck_power_mode_r   <= stored_defaults.buck_power_mode;
      linreg_power_mode_r <= stored_defaults.linreg_power_mode;
    end else begin
      if (wr_buck) begin
        buck_power_mode_r <= pwdata[7:0];
      end
      if (wr_lmode) begin
        linreg_power_mode_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      linreg_sequencer_source_r <= LINREG_SRC_RST;
    end else if (wr_lsrc) begin
      linreg_sequencer_source_r <= pwdata[7:0];
    end
  end

  // Wakeup follows an enable0 event only when the wake bit is set
  wire logic wakeup_nxt = enable0_input && wake_on_enable0_event_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup <= 1'b0;
    end else begin
      wakeup <= wakeup_nxt;
    end
  end

  // Slot period follows the sequencer phase
  logic [2:0] slot_code;
  always_comb begin
    unique case (seq_phase)
      PHASE_IDLE:        slot_code = 3'h0;
      PHASE_POWER_UP:    slot_code = master_powerup_period_r;
      PHASE_POWER_DOWN:  slot_code = master_powerdown_period_r;
      PHASE_SLEEP_ENTRY: slot_code = master_sleep_entry_period_r;
      PHASE_SLEEP_EXIT:  slot_code = master_sleep_exit_period_r;
      default:           slot_code = 3'h0;
    endcase
  end
  wire logic slot_run = (seq_phase != PHASE_IDLE) && (seq_phase <= PHASE_SLEEP_EXIT);

  psq_slot_timer #(
    .CNT_W    (SLOT_CNT_W),
    .SLOT_CYC (SLOT_CYC)
  ) u_slot_timer (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (slot_run),
    .code  (slot_code),
    .tick  (slot_tick)
  );

  // Regulator mode decode, one lane per regulator
  psq_reg_ctl_t buck_nxt;
  psq_reg_ctl_t linreg_nxt;

  generate
    for (genvar n = 0; n < NUM_BUCK; n++) begin : g_buck
      // Buck n sits at bits 2n+1:2n
      wire logic [1:0] mode = buck_power_mode_r[MODE_W*n +: MODE_W];
      assign buck_nxt.enable[n]   = (mode != MODE_OFF);
      assign buck_nxt.lowpower[n] = (mode == MODE_FOLLOW_LP) ? global_lowpower
                                  : (mode == MODE_FORCE_LP);
    end
    for (genvar n = 0; n < NUM_LINREG; n++) begin : g_linreg
      // Linreg 0 sits in the top field, linreg 3 in the bottom
      localparam int LSB = MODE_W * (NUM_LINREG - 1 - n);
      wire logic [1:0] mode     = linreg_power_mode_r[LSB +: MODE_W];
      wire logic [1:0] src      = linreg_sequencer_source_r[LSB +: MODE_W];
      wire logic       no_src   = (src == SRC_NONE);
      wire logic       seq_on   = no_src ? 1'b1 : flexible_sequencer_active[src];
      assign linreg_nxt.enable[n]   = (mode != MODE_OFF) && seq_on;
      assign linreg_nxt.lowpower[n] = (mode == MODE_FOLLOW_LP) ? global_lowpower
                                    : (mode == MODE_FORCE_LP);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_ctl   <= '0;
      linreg_ctl <= '0;
    end else begin
      buck_ctl   <= buck_nxt;
      linreg_ctl <= linreg_nxt;
    end
  end

endmodule : psq_regs
`default_nettype wire

/* File: tb/psq_regs_monitor.sv */
// Port checker for the sequencer register block.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ns
`default_nettype none
module psq_regs_monitor #(
  parameter logic [7:0][psq_pkg::SLOT_CNT_W-1:0] SLOT_CYC = psq_pkg::SLOT_CYC_DEF
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic [11:0]         paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                enable0_input,
  input wire logic                wakeup,
  input wire psq_pkg::psq_phase_t seq_phase,
  input wire logic                slot_tick
);
  import psq_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence one_wait;
    !pready ##1 pready;
  endsequence
  wake_gate_a: assert property (!$past(enable0_input) |-> !wakeup)
    else $error("wakeup without an enable0 event");
  slot_idle_a: assert property (($past(seq_phase) == PHASE_IDLE || $past(seq_phase) > PHASE_SLEEP_EXIT)
    |-> !slot_tick) else $error("slot tick while idle");
  ready_wait_a: assert property (psel && !penable |=> one_wait) else $error("wait state count wrong");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable)) else $error("pready unasked");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  bad_addr_a: assert property (pready && paddr[11:10] != 2'h0 |-> pslverr) else $error("bad address taken");
  good_addr_a: assert property (pready && paddr == 12'h254 |-> !pslverr)
    else $error("mapped address refused");
endmodule : psq_regs_monitor

bind psq_regs psq_regs_monitor #(.SLOT_CYC(SLOT_CYC)) i_psq_regs_monitor (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .enable0_input, .wakeup, .seq_phase, .slot_tick);
`default_nettype wire

/* File: tb/psq_regs_test.sv */
// Self-checking bench for the sequencer register block over APB.
// Assumes shortened slot periods; the bench drives every input itself.
`timescale 1ns/1ns
`default_nettype none
module psq_regs_test;
  import psq_pkg::*;
  localparam logic [7:0][SLOT_CNT_W-1:0] CYC = {20'h9, 20'h8, 20'h7, 20'h6, 20'h5, 20'h4, 20'h3, 20'h2};
  localparam logic [7:0] MODES [4] = '{8'h1B, 8'hE4, 8'h4E, 8'hB1};
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          enable0_input, global_lowpower, wakeup, slot_tick;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic [2:0]    seq_act;
  psq_phase_t    seq_phase;
  psq_defaults_t dflt;
  psq_reg_ctl_t  buck_ctl, linreg_ctl;
  int            n_mismatch, tests_run;

  psq_regs #(.SLOT_CYC(CYC)) i_psq_regs (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stored_defaults(dflt), .enable0_input(enable0_input),
    .global_lowpower(global_lowpower), .flexible_sequencer_active(seq_act), .seq_phase(seq_phase),
    .wakeup(wakeup), .slot_tick(slot_tick), .buck_ctl(buck_ctl), .linreg_ctl(linreg_ctl));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Called just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check(pready, 1'b1);
    check(pslverr, err);
    if (!w) check(prdata, exp);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input logic exp);
    enable0_input <= 1'b1;
    @(posedge pclk);
    enable0_input <= 1'b0;
    @(posedge pclk);
    check(wakeup, exp);
  endtask : pulse

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (slot_tick !== 1'b1 && n < 50);
  endtask : wait_tick

  // Expected {lowpower, enable}; linreg fields run from the top bits down
  function automatic logic [7:0] ctl(input logic [7:0] m, input logic [7:0] s, input logic rev);
    logic [7:0] r;
    logic [1:0] f, g;
    r = 8'h0;
    for (int i = 0; i < 4; i++) begin
      f = rev ? m[7-2*i -: 2] : m[2*i +: 2];
      g = rev ? s[7-2*i -: 2] : s[2*i +: 2];
      r[i] = f != 2'h0 && (g == 2'h3 || seq_act[g]);
      r[4+i] = f == 2'h2 || (f == 2'h1 && global_lowpower);
    end
    return r;
  endfunction : ctl

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    int n;
    int p;
    {presetn, psel, penable, pwrite, enable0_input, global_lowpower} = 6'h0;
    {paddr, pwdata, seq_act, n_mismatch, tests_run} = '0;
    seq_phase = PHASE_IDLE;
    dflt = {1'b1, 3'h1, 3'h2, 3'h3, 3'h4, 8'hE4, 8'h1B};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(12'h250, 1'b0, 32'h0, 32'h1, 1'b0);
    apb(12'h254, 1'b0, 32'h0, 32'h12, 1'b0);
    apb(12'h258, 1'b0, 32'h0, 32'h34, 1'b0);
    apb(12'h25C, 1'b0, 32'h0, 32'hE4, 1'b0);
    apb(12'h260, 1'b0, 32'h0, 32'h1B, 1'b0);
    check(buck_ctl, ctl(8'hE4, 8'hFF, 1'b0));
    check(linreg_ctl, ctl(8'h1B, 8'hFF, 1'b1));
    foreach (MODES[k]) begin
      global_lowpower <= k[0];
      apb(12'h25C, 1'b1, {24'h0, MODES[k]}, 32'h0, 1'b0);
      apb(12'h260, 1'b1, {24'h0, ~MODES[k]}, 32'h0, 1'b0);
      // Control outputs trail the register write by one more edge
      @(posedge pclk);
      check(buck_ctl, ctl(MODES[k], 8'hFF, 1'b0));
      check(linreg_ctl, ctl(~MODES[k], 8'hFF, 1'b1));
      apb(12'h284, 1'b0, 32'h0, {16'h0, ctl(~MODES[k], 8'hFF, 1'b1), ctl(MODES[k], 8'hFF, 1'b0)}, 1'b0);
    end
    apb(12'h260, 1'b1, 32'h6D, 32'h0, 1'b0);
    apb(12'h280, 1'b1, 32'h1B, 32'h0, 1'b0);
    for (int s = 0; s < 8; s++) begin
      seq_act <= 3'(s);
      repeat (3) @(posedge pclk);
      check(linreg_ctl, ctl(8'h6D, 8'h1B, 1'b1));
    end
    apb(12'h284, 1'b1, 32'hFF, 32'h0, 1'b0);
    apb(12'h300, 1'b0, 32'h0, 32'h0, 1'b1);
    apb(12'h654, 1'b1, 32'h77, 32'h0, 1'b1);
    apb(12'h254, 1'b0, 32'h0, 32'h12, 1'b0);
    pulse(1'b1);
    apb(12'h250, 1'b1, 32'h0, 32'h0, 1'b0);
    pulse(1'b0);
    for (int ph = 1; ph < 5; ph++) begin
      for (int c = 0; c < 8; c++) begin
        // Reserved bits 7 and 3 kept at zero
        apb(ph < 3 ? 12'h254 : 12'h258, 1'b1, {25'h0, 3'(c), 1'b0, 3'(7 - c)}, 32'h0, 1'b0);
        apb(ph < 3 ? 12'h254 : 12'h258, 1'b0, 32'h0, {25'h0, 3'(c), 1'b0, 3'(7 - c)}, 1'b0);
        p = int'(CYC[ph[0] ? c : 7 - c]);
        seq_phase <= psq_phase_t'(ph);
        wait_tick(n);
        check(32'(n), 32'(p + 1));
        wait_tick(n);
        check(32'(n), 32'(p));
        seq_phase <= PHASE_IDLE;
        repeat (2) @(posedge pclk);
      end
    end
    // Phase codes above sleep exit count as idle: no tick within the wait limit
    seq_phase <= psq_phase_t'(3'h5);
    wait_tick(n);
    check(32'(n), 32'd50);
    seq_phase <= PHASE_IDLE;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(12'h25C, 1'b0, 32'h0, 32'hE4, 1'b0);
    apb(12'h250, 1'b0, 32'h0, 32'h1, 1'b0);
    wrap_up();
  end
endmodule : psq_regs_test
`default_nettype wire
